// >>> design/bss_pkg.sv
package bss_pkg;

  // ==========================================================================
  // Field and memory sizes
  // ==========================================================================
  localparam int FIELD_W     = 4;
  localparam int ROM_KB      = 64;
  localparam int ROM_BYTES   = ROM_KB * 1024;
  localparam int SRAM_KB     = 200;
  localparam int SRAM_BYTES  = SRAM_KB * 1024;
  localparam int SRAM_ADDR_W = 18;
  localparam int DATA_W      = 8;
  localparam int QUAD_PINS   = 6;

  localparam logic [FIELD_W-1:0]   FIELD_BLANK    = 4'h0;
  localparam logic [FIELD_W-1:0]   FIELD_RSV_LOW  = 4'ha;
  localparam logic [QUAD_PINS-1:0] QUAD_PINS_ALL  = 6'h3f;
  localparam logic [QUAD_PINS-1:0] QUAD_PINS_NONE = 6'h00;

  // ==========================================================================
  // Boot-source codes, as held in the one-time-programmable field
  // ==========================================================================
  typedef enum logic [3:0] {
    SRC_PIN_STATE    = 4'h0,
    SRC_SERIAL_ZERO  = 4'h1,
    SRC_QUAD_FLASH   = 4'h2,
    SRC_EXT_MEM8     = 4'h3,
    SRC_EXT_MEM16    = 4'h4,
    SRC_EXT_MEM32    = 4'h5,
    SRC_USB_FIRST    = 4'h6,
    SRC_USB_SECOND   = 4'h7,
    SRC_SYNC_SERIAL  = 4'h8,
    SRC_SERIAL_THREE = 4'h9,
    SRC_NONE         = 4'hf
  } bss_src_t;

  typedef enum logic [1:0] {
    BUS_NONE = 2'h0,
    BUS_8    = 2'h1,
    BUS_16   = 2'h2,
    BUS_32   = 2'h3
  } bss_width_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic bootStrapPinD;
    logic bootStrapPinC;
    logic bootStrapPinB;
    logic bootStrapPinA;
  } bss_strap_t;

  typedef struct packed {
    logic [QUAD_PINS-1:0] quadPins;
    logic                 syncSerialClockPin;
    logic                 syncSerialSelectPin;
    logic                 syncSerialInputPin;
    logic                 syncSerialOutputPin;
    logic                 serialPortZero;
    logic                 serialPortThree;
    logic                 chipSelectZero;
    logic                 usbPortFirst;
    logic                 usbPortSecond;
  } bss_pins_t;

  typedef struct packed {
    logic       valid;
    bss_src_t   src;
    bss_width_t memWidth;
    bss_pins_t  pins;
  } bss_cfg_t;

  // ==========================================================================
  // Boot sequence states
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_SAMPLE   = 6'h01,
    ST_WAIT_OTP = 6'h02,
    ST_DECODE   = 6'h04,
    ST_DONE     = 6'h08,
    ST_ISP_LOAD = 6'h10,
    ST_ISP_RUN  = 6'h20
  } bss_state_t;

endpackage

// >>> design/bss_decode.sv
`timescale 1ns/1ps
module bss_decode
  import bss_pkg::*;
(
  // Selected code
  input  wire logic [bss_pkg::FIELD_W-1:0] code,
  // Decoded configuration
  output bss_pkg::bss_cfg_t                cfg
);

  always_comb begin
    cfg = '0;
    cfg.src = SRC_NONE;
    cfg.memWidth = BUS_NONE;
    case (code)
      // RULE_03: serial port zero
      4'h1: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_SERIAL_ZERO;
        cfg.pins.serialPortZero = 1'b1;
      end
      // RULE_04: quad flash pins
      4'h2: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_QUAD_FLASH;
        cfg.pins.quadPins = QUAD_PINS_ALL;
      end
      // RULE_05: external memory widths
      4'h3: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_EXT_MEM8;
        cfg.memWidth = BUS_8;
        cfg.pins.chipSelectZero = 1'b1;
      end
      4'h4: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_EXT_MEM16;
        cfg.memWidth = BUS_16;
        cfg.pins.chipSelectZero = 1'b1;
      end
      4'h5: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_EXT_MEM32;
        cfg.memWidth = BUS_32;
        cfg.pins.chipSelectZero = 1'b1;
      end
      // RULE_09: usb port selection
      4'h6: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_USB_FIRST;
        cfg.pins.usbPortFirst = 1'b1;
      end
      4'h7: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_USB_SECOND;
        cfg.pins.usbPortSecond = 1'b1;
      end
      // RULE_06: sync serial pins
      4'h8: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_SYNC_SERIAL;
        cfg.pins.syncSerialClockPin = 1'b1;
        cfg.pins.syncSerialSelectPin = 1'b1;
        cfg.pins.syncSerialInputPin = 1'b1;
        cfg.pins.syncSerialOutputPin = 1'b1;
      end
      // RULE_03: serial port three
      4'h9: begin
        cfg.valid = 1'b1;
        cfg.src = SRC_SERIAL_THREE;
        cfg.pins.serialPortThree = 1'b1;
      end
      // Reserved codes, and a blank strap code, leave every source off.
      default: begin
        cfg.valid = 1'b0;
      end
    endcase
  end

endmodule

// >>> design/bss_boot_source_select.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01: After reset, fetch from 64 kB boot ROM.
// RULE_02: Blank or zero field uses strap pins.
// RULE_03: Codes 1, 9 pick serial zero, three.
// RULE_04: Code 2 picks quad flash, six pins.
// RULE_05: Codes 3-5 pick 8/16/32-bit external memory.
// RULE_06: Code 8 picks SPI flash on sync serial.
// RULE_07: Quad and sync pin setups differ.
// RULE_08: Programming mode loads RAM, then runs it.
// RULE_09: Codes 6, 7 USB; 10-15 reserved.
module bss_boot_source_select #(
  parameter int SRAM_LIMIT = bss_pkg::SRAM_BYTES
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  // One-time-programmable field
  input  wire logic                            otpReady,
  input  wire logic                            otpProgrammed,
  input  wire logic [bss_pkg::FIELD_W-1:0]     otpBootField,
  // Boot-strap pins
  input  bss_pkg::bss_strap_t                  bootStrap,
  // Programming byte stream from serial port zero
  input  wire logic                            rxValid,
  input  wire logic [bss_pkg::DATA_W-1:0]      rxData,
  input  wire logic                            ispGo,
  output logic                                 rxReady,
  // On-chip RAM write port
  output logic                                 sramWe,
  output logic [bss_pkg::SRAM_ADDR_W-1:0]      sramAddr,
  output logic [bss_pkg::DATA_W-1:0]           sramData,
  // Boot result
  output logic                                 bootDone,
  output bss_pkg::bss_cfg_t                    bootCfg,
  output logic                                 fetchFromRom,
  output logic                                 execFromSram,
  output logic                                 ispActive
);
  import bss_pkg::*;

  localparam logic [SRAM_ADDR_W:0] LIMIT = (SRAM_ADDR_W+1)'(SRAM_LIMIT);

  // ==========================================================================
  // State
  // ==========================================================================
  bss_state_t              state_q;
  bss_strap_t              strap_q;
  logic [FIELD_W-1:0]      code_q;
  logic                    fromStraps_q;
  bss_cfg_t                bootCfg_q;
  logic                    bootDone_q;
  logic                    fetchFromRom_q;
  logic                    execFromSram_q;
  logic                    rxReady_q;
  logic                    sramWe_q;
  logic [SRAM_ADDR_W-1:0]  sramAddr_q;
  logic [DATA_W-1:0]       sramData_q;
  logic [SRAM_ADDR_W:0]    fill_q;
  logic                    useStraps;
  logic [FIELD_W-1:0]      selCode;
  bss_cfg_t                selCfg;
  logic                    rxTake;
  logic                    cfgHeld;

  // RULE_02: strap fallback select
  assign useStraps = !otpProgrammed || (otpBootField == FIELD_BLANK);
  assign selCode   = useStraps ? strap_q : otpBootField;
  assign rxTake    = (state_q == ST_ISP_LOAD) && rxValid && rxReady_q;
  assign cfgHeld   = (state_q == ST_DONE) || (state_q == ST_ISP_LOAD) || (state_q == ST_ISP_RUN);

  bss_decode uDecode (
    .code (selCode),
    .cfg  (selCfg)
  );

  // ==========================================================================
  // Boot sequence
  // ==========================================================================
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_SAMPLE;
    end else begin
      case (state_q)
        ST_SAMPLE:   state_q <= ST_WAIT_OTP;
        ST_WAIT_OTP: state_q <= otpReady ? ST_DECODE : ST_WAIT_OTP;
        ST_DECODE:   state_q <= (selCfg.src == SRC_SERIAL_ZERO) ? ST_ISP_LOAD : ST_DONE;
        ST_DONE:     state_q <= ST_DONE;
        ST_ISP_LOAD: state_q <= ispGo ? ST_ISP_RUN : ST_ISP_LOAD;
        ST_ISP_RUN:  state_q <= ST_ISP_RUN;
        default:     state_q <= ST_SAMPLE;
      endcase
    end
  end

  // Straps are caught on the first edge after release, never by the reset itself.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_q <= '0;
    end else if (state_q == ST_SAMPLE) begin
      strap_q <= bootStrap;
    end
  end

  // RULE_07: pin functions set once
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bootCfg_q    <= '0;
      code_q       <= FIELD_BLANK;
      fromStraps_q <= 1'b0;
    end else if (state_q == ST_DECODE) begin
      bootCfg_q    <= selCfg;
      code_q       <= selCode;
      fromStraps_q <= useStraps;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bootDone_q <= 1'b0;
    end else if (state_q == ST_DECODE) begin
      bootDone_q <= (selCfg.src != SRC_SERIAL_ZERO);
    end
  end

  // RULE_01: boot ROM owns fetch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fetchFromRom_q <= 1'b1;
      execFromSram_q <= 1'b0;
    end else if ((state_q == ST_ISP_LOAD) && ispGo) begin
      fetchFromRom_q <= 1'b0;
      execFromSram_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Programming mode load path
  // ==========================================================================
  // RULE_08: accept bytes into RAM
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rxReady_q <= 1'b0;
    end else if ((state_q == ST_DECODE) && (selCfg.src == SRC_SERIAL_ZERO)) begin
      rxReady_q <= 1'b1;
    end else if ((state_q == ST_ISP_LOAD) && (ispGo || (rxTake && (fill_q + 1'b1 >= LIMIT)))) begin
      rxReady_q <= 1'b0;
    end
  end

  // Bytes past the RAM limit are refused by dropping ready rather than wrapping over code.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sramWe_q   <= 1'b0;
      sramAddr_q <= '0;
      sramData_q <= '0;
      fill_q     <= '0;
    end else begin
      sramWe_q <= rxTake;
      if (rxTake) begin
        sramAddr_q <= fill_q[SRAM_ADDR_W-1:0];
        sramData_q <= rxData;
        fill_q     <= fill_q + 1'b1;
      end
    end
  end

  assign rxReady      = rxReady_q;
  assign sramWe       = sramWe_q;
  assign sramAddr     = sramAddr_q;
  assign sramData     = sramData_q;
  assign bootDone     = bootDone_q;
  assign bootCfg      = bootCfg_q;
  assign fetchFromRom = fetchFromRom_q;
  assign execFromSram = execFromSram_q;
  assign ispActive    = rxReady_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_rom_fetch_owner: assert property ( // RULE_01
    (fetchFromRom_q != execFromSram_q) and (execFromSram_q |-> state_q == ST_ISP_RUN))
    else $error("Fetch source is not exclusive or ran RAM too early.");

  chk_strap_fallback: assert property ( // RULE_02
    (state_q == ST_DECODE) |=>
      (code_q == ($past(!otpProgrammed || (otpBootField == 4'h0)) ?
                  $past(strap_q) : $past(otpBootField))))
    else $error("Boot code was not taken from the correct source.");

  chk_serial_ports: assert property ( // RULE_03
    cfgHeld && (code_q == 4'h1 || code_q == 4'h9) |->
      (bootCfg_q.pins.serialPortZero == (code_q == 4'h1)) &&
      (bootCfg_q.pins.serialPortThree == (code_q == 4'h9)) && bootCfg_q.valid)
    else $error("Serial port selection does not match the code.");

  chk_quad_pins: assert property ( // RULE_04
    cfgHeld && (code_q == 4'h2) |->
      (bootCfg_q.src == SRC_QUAD_FLASH) && (bootCfg_q.pins.quadPins == QUAD_PINS_ALL))
    else $error("Quad flash boot lacks its six pins.");

  chk_ext_width: assert property ( // RULE_05
    cfgHeld && (code_q inside {4'h3, 4'h4, 4'h5}) |->
      bootCfg_q.pins.chipSelectZero &&
      (bootCfg_q.memWidth == ((code_q == 4'h3) ? BUS_8 : (code_q == 4'h4) ? BUS_16 : BUS_32)))
    else $error("External memory width does not match the code.");

  chk_sync_pins: assert property ( // RULE_06
    cfgHeld && (code_q == 4'h8) |->
      (bootCfg_q.src == SRC_SYNC_SERIAL) && bootCfg_q.pins.syncSerialClockPin &&
      bootCfg_q.pins.syncSerialSelectPin && bootCfg_q.pins.syncSerialInputPin &&
      bootCfg_q.pins.syncSerialOutputPin)
    else $error("Sync serial boot lacks its pin functions.");

  chk_pin_exclusive: assert property ( // RULE_07
    !((|bootCfg_q.pins.quadPins) && bootCfg_q.pins.syncSerialClockPin) and
    ((state_q != ST_DECODE) |=> $stable(bootCfg_q)))
    else $error("Pin setup changed or overlapped.");

  chk_isp_write: assert property ( // RULE_08
    rxTake |=> sramWe_q && (sramData_q == $past(rxData)) && (fill_q == $past(fill_q) + 1'b1))
    else $error("Programming byte was not written to RAM.");

  chk_isp_run: assert property ( // RULE_08
    (state_q == ST_ISP_LOAD) && ispGo |=> execFromSram_q && !rxReady_q ##1 execFromSram_q)
    else $error("RAM execution did not follow the go request.");

  chk_reserved_none: assert property ( // RULE_09
    cfgHeld && (code_q >= FIELD_RSV_LOW || code_q == FIELD_BLANK) |->
      !bootCfg_q.valid && (bootCfg_q.src == SRC_NONE) && bootDone_q)
    else $error("Reserved code selected a boot source.");

  chk_usb_ports: assert property ( // RULE_09
    cfgHeld && (code_q inside {4'h6, 4'h7}) |->
      (bootCfg_q.pins.usbPortFirst == (code_q == 4'h6)) &&
      (bootCfg_q.pins.usbPortSecond == (code_q == 4'h7)))
    else $error("USB port selection does not match the code.");

  cov_otp_boot:    cover property ((state_q == ST_DECODE) && !useStraps ##1 bootDone_q);
  cov_strap_boot:  cover property ((state_q == ST_DECODE) && useStraps ##1 bootDone_q);
  cov_isp_run:     cover property (rxTake ##[1:20] ((state_q == ST_ISP_LOAD) && ispGo));
  cov_reserved:    cover property (bootDone_q && !bootCfg_q.valid);

endmodule

// >>> verification/bss_host_model.sv
`timescale 1ns/1ps
// ============================================================================
// Serial download host seen through serial port zero
// ============================================================================
module bss_host_model (
  // Clock
  input  wire logic       clock,
  // Byte stream handshake
  input  wire logic       rxReady,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            ispGo
);
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h5a;
    ispGo   = 1'b0;
  end

  // host sends bytes
  // A byte is held until rxReady is seen high after an edge; after 21 cycles with rxReady low the host gives up.
  task automatic send(input int n, input logic go);
    int w;
    for (int i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxData  <= 8'(8'ha0 + i);
      ispGo   <= go && (i == n - 1);
      w = 0;
      @(posedge clock);
      while (!rxReady && w < 20) begin
        w++;
        @(posedge clock);
      end
      if (!rxReady) begin
        break;
      end
    end
    rxValid <= 1'b0;
    ispGo   <= 1'b0;
    // Released data does not keep its last value.
    rxData  <= ~rxData;
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import bss_pkg::*;
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             otpReady = 1'b0;
  logic             otpProgrammed = 1'b0;
  logic [3:0]       otpBootField = 4'h0;
  bss_strap_t       bootStrap = '0;
  logic             rxValid, ispGo, rxReady, sramWe, bootDone;
  logic             fetchFromRom, execFromSram, ispActive;
  logic [7:0]       rxData, sramData;
  logic [17:0]      sramAddr;
  logic [17:0]      expAddr = '0;
  bss_cfg_t         bootCfg;
  int               fails = 0;
  int               comparisons = 0;
  // Rows: programmed, field, straps, effective code.
  logic [12:0]      rows [15] = '{13'h1101, 13'h1202, 13'h1303, 13'h1404, 13'h1505,
                                  13'h1606, 13'h1707, 13'h1808, 13'h1909, 13'h1a0a,
                                  13'h1f0f, 13'h0388, 13'h1055, 13'h1000, 13'h0011};

  bss_boot_source_select #(.SRAM_LIMIT(4)) dut (
    .clock(clock), .sys_rst(sys_rst), .otpReady(otpReady), .otpProgrammed(otpProgrammed),
    .otpBootField(otpBootField), .bootStrap(bootStrap), .rxValid(rxValid), .rxData(rxData),
    .ispGo(ispGo), .rxReady(rxReady), .sramWe(sramWe), .sramAddr(sramAddr),
    .sramData(sramData), .bootDone(bootDone), .bootCfg(bootCfg),
    .fetchFromRom(fetchFromRom), .execFromSram(execFromSram), .ispActive(ispActive));

  bss_host_model host (
    .clock(clock), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .ispGo(ispGo));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ==========================================================================
  // Expected configuration per effective code
  // ==========================================================================
  function automatic bss_cfg_t exp_cfg(logic [3:0] c);
    bss_cfg_t e;
    e = '0;
    e.src = SRC_NONE;
    if (c >= 4'h1 && c <= 4'h9) begin
      e.valid = 1'b1;
      e.src   = bss_src_t'(c);
    end
    e.memWidth = (c == 4'h3) ? BUS_8 : (c == 4'h4) ? BUS_16 : (c == 4'h5) ? BUS_32 : BUS_NONE;
    e.pins.quadPins = (c == 4'h2) ? QUAD_PINS_ALL : QUAD_PINS_NONE;
    e.pins.syncSerialClockPin  = (c == 4'h8);
    e.pins.syncSerialSelectPin = (c == 4'h8);
    e.pins.syncSerialInputPin  = (c == 4'h8);
    e.pins.syncSerialOutputPin = (c == 4'h8);
    e.pins.serialPortZero  = (c == 4'h1);
    e.pins.serialPortThree = (c == 4'h9);
    e.pins.chipSelectZero  = (c >= 4'h3 && c <= 4'h5);
    e.pins.usbPortFirst    = (c == 4'h6);
    e.pins.usbPortSecond   = (c == 4'h7);
    return e;
  endfunction

  task automatic boot(input logic [12:0] r, input logic rdy);
    sys_rst       <= 1'b1;
    otpProgrammed <= r[12];
    otpBootField  <= r[11:8];
    bootStrap     <= bss_strap_t'(r[7:4]);
    otpReady      <= rdy;
    repeat (6) @(posedge clock);
    `CHK("fetchFromRom", 1'b1, fetchFromRom)
    `CHK("bootCfg", bss_cfg_t'(0), bootCfg)
    sys_rst <= 1'b0;
  endtask

  task automatic stop_test;
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (sys_rst) begin
      expAddr <= '0;
    end else if (sramWe === 1'b1) begin
      `CHK("sramAddr", expAddr, sramAddr)
      `CHK("sramData", 8'(8'ha0 + expAddr[7:0]), sramData)
      expAddr <= expAddr + 18'h1;
    end
  end

  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    stop_test();
  end

  initial begin
    @(posedge clock);
    foreach (rows[i]) begin
      boot(rows[i], 1'b1);
      repeat (8) @(posedge clock);
      `CHK("bootCfg", exp_cfg(rows[i][3:0]), bootCfg)
      `CHK("bootDone", rows[i][3:0] != 4'h1, bootDone)
      `CHK("rxReady", rows[i][3:0] == 4'h1, rxReady)
      `CHK("fetchFromRom", 1'b1, fetchFromRom)
    end
    // Late field ready; straps move after capture and must be ignored.
    boot(13'h0030, 1'b0);
    repeat (10) @(posedge clock);
    `CHK("bootDone", 1'b0, bootDone)
    bootStrap <= bss_strap_t'(4'h5);
    otpReady  <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("bootCfg", exp_cfg(4'h3), bootCfg)
    otpBootField <= 4'h8;
    otpProgrammed <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("bootCfg", exp_cfg(4'h3), bootCfg)
    // Ready drops as the fourth byte reaches the RAM limit, so the host offers a fifth byte but gives up on it.
    boot(13'h1100, 1'b1);
    repeat (8) @(posedge clock);
    host.send(5, 1'b0);
    repeat (3) @(posedge clock);
    `CHK("byteCount", 18'h4, expAddr)
    `CHK("rxReady", 1'b0, rxReady)
    `CHK("execFromSram", 1'b0, execFromSram)
    // Load ends with run request on the last byte.
    boot(13'h1100, 1'b1);
    repeat (8) @(posedge clock);
    `CHK("ispActive", 1'b1, ispActive)
    host.send(2, 1'b1);
    repeat (3) @(posedge clock);
    `CHK("byteCount", 18'h2, expAddr)
    `CHK("execFromSram", 1'b1, execFromSram)
    `CHK("fetchFromRom", 1'b0, fetchFromRom)
    `CHK("ispActive", 1'b0, ispActive)
    stop_test();
  end
endmodule
